/* File: logic/sens_err_cfg.svh */
// Constants for the sensitivity and error reporter
`ifndef SENS_ERR_CFG_SVH
`define SENS_ERR_CFG_SVH
`define CH_HASH 8'h23
`define CH_CR 8'h0D
`define CH_0 8'h30
`define CH_1 8'h31
`define CH_3 8'h33
`define CH_4 8'h34
`define CH_5 8'h35
`define CH_6 8'h36
`define CH_7 8'h37
`define CH_9 8'h39
`define CH_A 8'h41
`define CH_F 8'h46
`define CH_a 8'h61
`define CH_f 8'h66
`define RANGE_MAX 5'h1F
`define RANGE_MIN 5'h00
`define LINE_MAX 4'h8
`define BAUD_DEFAULT 17'h02580
`define DATA_BITS_DEFAULT 4'h8
`define STOP_BITS_DEFAULT 2'h1
`define PARITY_DEFAULT 1'b0
`define SERIAL_DEFAULT {`BAUD_DEFAULT, `DATA_BITS_DEFAULT, `STOP_BITS_DEFAULT, `PARITY_DEFAULT}
`define POS_D0 0
`define POS_D1 1
`define POS_D2 2
`define POS_ARG_HI 3
`define POS_ARG_LO 4
`define LEN_MODE_CMD 4'h2
`define LEN_CODE 4'h3
`define LEN_RANGE_CMD 4'h5
`define LEN_FREQ_CMD 4'h6
`define HEX_BAD 5'h10
`define HEX_LETTER_BASE 8'h0A
`endif

/* File: logic/sens_err_pkg.sv */
// Types for the sensitivity and error reporter
package sens_err_pkg;
  typedef enum logic [3:0] {
    MSG_NONE,
    MSG_DONE,
    MSG_ERR_GENERIC,
    MSG_ERR06,
    MSG_ERR07,
    MSG_ERR08,
    MSG_ERR_RF1,
    MSG_ERR_RF2,
    MSG_ERR_RF3
  } msg_code_t;
  typedef struct packed {
    msg_code_t code;
    logic [7:0] status;
  } report_t;
  typedef struct packed {
    logic [16:0] baud;
    logic [3:0] data_bits;
    logic [1:0] stop_bits;
    logic parity_en;
  } serial_cfg_t;
endpackage

/* File: logic/sticky_event.sv */
// Sticky event flag, set beats clear
`timescale 1ns/1ns
module sticky_event
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic flag_ff
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_ff <= 1'b0;
    else if (set)
      flag_ff <= 1'b1;
    else if (clr)
      flag_ff <= 1'b0;
  end
endmodule // sticky_event

/* File: logic/sens_err_reporter.sv */
// Command interpreter for sensitivity range and error reporting
`timescale 1ns/1ns
`include "sens_err_cfg.svh"
module sens_err_reporter
  import sens_err_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_CHAR,
  input wire logic DIAG_FAIL,
  input wire logic PARAM_LOST,
  input wire logic PLL_LOCK,
  input wire logic RF_ACK_TIMEOUT,
  input wire logic RF_INIT_TIMEOUT,
  input wire logic RF_STATUS_BAD,
  input wire logic [7:0] RF_STATUS_BYTE,
  input wire logic RF_ENABLE_REQ,
  output logic [4:0] TRUCK_TAG_PROTOCOL_RANGE,
  output logic [4:0] ALT_PROTOCOL_RANGE,
  output logic CMD_MODE,
  output logic RF_ON,
  output logic REPORT_VALID,
  output report_t REPORT,
  output serial_cfg_t SERIAL_CFG
);
  typedef enum logic [1:0] {
    LINE_IDLE,
    LINE_BODY,
    LINE_DROP
  } line_state_t;

  line_state_t line_ff;
  logic [7:0] buf_ff [0:7];
  logic [3:0] len_ff;
  logic exec, hi_ok, lo_ok, arg_ok;
  logic [4:0] hex_hi, hex_lo, arg;
  logic is_01, is_00, is_643, is_645, is_647;
  logic [4:0] nxt_truck, nxt_alt;
  msg_code_t cmd_msg;
  logic pll_lock_d_ff;
  logic lock_lost_ff;
  logic rf_before_ff;
  logic param_block_ff;
  logic pll_fall, pll_rise;
  logic ev_set [0:6];
  logic ev_clr [0:6];
  logic ev_flag [0:6];
  logic [7:0] status_ff;
  logic [2:0] pick;
  logic pick_any;

  ////////////////////////////////////////////////////////////////////////////
  // Line assembly
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      line_ff <= LINE_IDLE;
    else if (RX_VALID)
    begin
      unique case (line_ff)
        LINE_IDLE:
          if (RX_CHAR == `CH_HASH)
            line_ff <= LINE_BODY;
        LINE_BODY:
          if (RX_CHAR == `CH_CR)
            line_ff <= LINE_IDLE;
          else if (len_ff == `LINE_MAX)
            line_ff <= LINE_DROP;
        LINE_DROP:
          if (RX_CHAR == `CH_CR)
            line_ff <= LINE_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      len_ff <= 4'h0;
    else if (RX_VALID && line_ff == LINE_IDLE)
      len_ff <= 4'h0;
    else if (RX_VALID && line_ff == LINE_BODY && RX_CHAR != `CH_CR && len_ff != `LINE_MAX)
      len_ff <= len_ff + 4'h1;
  end

  always_ff @(posedge CLK)
  begin
    if (RX_VALID && line_ff == LINE_BODY && len_ff != `LINE_MAX)
      buf_ff[len_ff[2:0]] <= RX_CHAR;
  end

  // Terminator seen: parse now
  assign exec = RX_VALID && (RX_CHAR == `CH_CR) && (line_ff != LINE_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [4:0] v;
    v = `HEX_BAD;
    if (c >= `CH_0 && c <= `CH_9)
      v = {1'b0, 4'(c - `CH_0)};
    else if (c >= `CH_A && c <= `CH_F)
      v = {1'b0, 4'(c - `CH_A + `HEX_LETTER_BASE)};
    else if (c >= `CH_a && c <= `CH_f)
      v = {1'b0, 4'(c - `CH_a + `HEX_LETTER_BASE)};
    return v;
  endfunction

  always_comb
  begin
    hex_hi = hex_val(buf_ff[`POS_ARG_HI]);
    hex_lo = hex_val(buf_ff[`POS_ARG_LO]);
    hi_ok = !hex_hi[4] && hex_hi[3:1] == 3'h0;
    lo_ok = !hex_lo[4];
    arg = {hex_hi[0], hex_lo[3:0]};
    arg_ok = hi_ok && lo_ok && (len_ff == `LEN_RANGE_CMD) && line_ff == LINE_BODY;
    is_01 = len_ff == `LEN_MODE_CMD && buf_ff[`POS_D0] == `CH_0 && buf_ff[`POS_D1] == `CH_1;
    is_00 = len_ff == `LEN_MODE_CMD && buf_ff[`POS_D0] == `CH_0 && buf_ff[`POS_D1] == `CH_0;
    is_643 = len_ff >= `LEN_CODE && buf_ff[`POS_D0] == `CH_6 && buf_ff[`POS_D1] == `CH_4
      && buf_ff[`POS_D2] == `CH_3;
    is_645 = len_ff >= `LEN_CODE && buf_ff[`POS_D0] == `CH_6 && buf_ff[`POS_D1] == `CH_4
      && buf_ff[`POS_D2] == `CH_5;
    is_647 = len_ff == `LEN_FREQ_CMD && buf_ff[`POS_D0] == `CH_6 && buf_ff[`POS_D1] == `CH_4
      && buf_ff[`POS_D2] == `CH_7 && line_ff == LINE_BODY;
  end

  // Command results
  always_comb
  begin
    nxt_truck = TRUCK_TAG_PROTOCOL_RANGE;
    nxt_alt = ALT_PROTOCOL_RANGE;
    cmd_msg = MSG_NONE;
    if (exec)
    begin
      if (is_01)
        cmd_msg = MSG_DONE;
      else if (is_00)
        cmd_msg = MSG_NONE;
      else if ((is_643 || is_645) && CMD_MODE && arg_ok)
      begin
        if (is_643)
          nxt_truck = arg;
        else
          nxt_alt = arg;
      end
      else if (is_647 && CMD_MODE)
        cmd_msg = MSG_NONE;
      else
        cmd_msg = MSG_ERR_GENERIC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and range storage
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      CMD_MODE <= 1'b0;
    else if (exec && is_01)
      CMD_MODE <= 1'b1;
    else if (exec && is_00)
      CMD_MODE <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      TRUCK_TAG_PROTOCOL_RANGE <= `RANGE_MAX;
      ALT_PROTOCOL_RANGE <= `RANGE_MAX;
    end
    else
    begin
      TRUCK_TAG_PROTOCOL_RANGE <= nxt_truck;
      ALT_PROTOCOL_RANGE <= nxt_alt;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      SERIAL_CFG <= `SERIAL_DEFAULT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // RF state tracking
  assign pll_fall = pll_lock_d_ff && !PLL_LOCK;
  assign pll_rise = !pll_lock_d_ff && PLL_LOCK;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      pll_lock_d_ff <= 1'b1;
    else
      pll_lock_d_ff <= PLL_LOCK;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      lock_lost_ff <= 1'b0;
    else if (pll_fall)
      lock_lost_ff <= 1'b1;
    else if (pll_rise && lock_lost_ff)
      lock_lost_ff <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rf_before_ff <= 1'b0;
    else if (pll_fall && !lock_lost_ff)
      rf_before_ff <= RF_ON;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      param_block_ff <= 1'b0;
    else if (PARAM_LOST)
      param_block_ff <= 1'b1;
    else if (exec && is_647 && CMD_MODE)
      param_block_ff <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      RF_ON <= 1'b0;
    else if (PARAM_LOST || param_block_ff)
      RF_ON <= 1'b0;
    else if (pll_fall || (lock_lost_ff && !pll_rise))
      RF_ON <= 1'b0;
    else if (pll_rise && lock_lost_ff)
      RF_ON <= rf_before_ff;
    else
      RF_ON <= RF_ENABLE_REQ;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending event flags
  always_comb
  begin
    ev_set[0] = DIAG_FAIL;
    ev_set[1] = PARAM_LOST;
    ev_set[2] = pll_fall;
    ev_set[3] = pll_rise && lock_lost_ff;
    ev_set[4] = RF_ACK_TIMEOUT;
    ev_set[5] = RF_INIT_TIMEOUT;
    ev_set[6] = RF_STATUS_BAD;
    pick = 3'h0;
    pick_any = 1'b0;
    for (int i = 6; i >= 0; i--)
    begin
      if (ev_flag[i])
      begin
        pick = 3'(i);
        pick_any = 1'b1;
      end
    end
    for (int i = 0; i < 7; i++)
      ev_clr[i] = pick_any && (cmd_msg == MSG_NONE) && (pick == 3'(i));
  end

  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : g_ev
      sticky_event u_ev
      (
        .clk(CLK),
        .rst_n(RST_N),
        .set(ev_set[g]),
        .clr(ev_clr[g]),
        .flag_ff(ev_flag[g])
      );
    end
  endgenerate

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      status_ff <= 8'h00;
    else if (RF_STATUS_BAD)
      status_ff <= RF_STATUS_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Report output, command replies first
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REPORT_VALID <= 1'b0;
      REPORT <= '{code: MSG_NONE, status: 8'h00};
    end
    else if (cmd_msg != MSG_NONE)
    begin
      REPORT_VALID <= 1'b1;
      REPORT <= '{code: cmd_msg, status: 8'h00};
    end
    else if (pick_any)
    begin
      REPORT_VALID <= 1'b1;
      unique case (pick)
        3'h0: REPORT <= '{code: MSG_ERR_GENERIC, status: 8'h00};
        3'h1: REPORT <= '{code: MSG_ERR06, status: 8'h00};
        3'h2: REPORT <= '{code: MSG_ERR07, status: 8'h00};
        3'h3: REPORT <= '{code: MSG_ERR08, status: 8'h00};
        3'h4: REPORT <= '{code: MSG_ERR_RF1, status: 8'h00};
        3'h5: REPORT <= '{code: MSG_ERR_RF2, status: 8'h00};
        default: REPORT <= '{code: MSG_ERR_RF3, status: status_ff};
      endcase
    end
    else
      REPORT_VALID <= 1'b0;
  end
endmodule // sens_err_reporter

/* File: dv/sens_err_monitor.sv */
// Assertion checker for the sensitivity and error reporter
`timescale 1ns/1ns
`include "sens_err_cfg.svh"
module sens_err_monitor
  import sens_err_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_CHAR,
  input wire logic PLL_LOCK,
  input wire logic RF_ACK_TIMEOUT,
  input wire logic RF_STATUS_BAD,
  input wire logic [7:0] RF_STATUS_BYTE,
  input wire logic [4:0] TRUCK_TAG_PROTOCOL_RANGE,
  input wire logic [4:0] ALT_PROTOCOL_RANGE,
  input wire logic CMD_MODE,
  input wire logic RF_ON,
  input wire logic REPORT_VALID,
  input wire report_t REPORT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] bad_ff;
  logic lost_ff;
  logic cr_cmd;
  // Terminator taken while in command mode
  assign cr_cmd = RX_VALID && RX_CHAR == `CH_CR && CMD_MODE;
  ////////////////////////////////////////////////////////////////
  // Latest bad status and lock-loss report memory
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      bad_ff <= 8'h00;
    else if (RF_STATUS_BAD)
      bad_ff <= RF_STATUS_BYTE;
  end
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      lost_ff <= 1'b0;
    else if (REPORT_VALID && REPORT.code == MSG_ERR07)
      lost_ff <= 1'b1;
    else if (REPORT_VALID && REPORT.code == MSG_ERR08)
      lost_ff <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_rep(msg_code_t c);
    REPORT_VALID && REPORT.code == c;
  endsequence
  a_truck_on_cr: assert property ($changed(TRUCK_TAG_PROTOCOL_RANGE) |-> $past(cr_cmd))
    else $error("truck range changed without command line");
  a_alt_on_cr: assert property ($changed(ALT_PROTOCOL_RANGE) |-> $past(cr_cmd))
    else $error("alt range changed without command line");
  a_done_mode: assert property (s_rep(MSG_DONE) |-> CMD_MODE)
    else $error("done prompt outside command mode");
  a_rf_off_loss: assert property (!PLL_LOCK |=> !RF_ON)
    else $error("rf on while unlocked");
  a_loss_report: assert property ($fell(PLL_LOCK) |-> ##[2:16] s_rep(MSG_ERR07))
    else $error("lock loss not reported");
  a_relock_order: assert property (s_rep(MSG_ERR08) |-> lost_ff)
    else $error("relock report without loss report");
  a_ack_warn: assert property (RF_ACK_TIMEOUT |-> ##[2:16] s_rep(MSG_ERR_RF1))
    else $error("ack warning missing");
  a_status_byte: assert property (s_rep(MSG_ERR_RF3) |-> REPORT.status == bad_ff)
    else $error("status byte wrong");
endmodule // sens_err_monitor
bind sens_err_reporter sens_err_monitor mon (.CLK, .RST_N, .RX_VALID, .RX_CHAR, .PLL_LOCK, .RF_ACK_TIMEOUT,
  .RF_STATUS_BAD, .RF_STATUS_BYTE, .TRUCK_TAG_PROTOCOL_RANGE, .ALT_PROTOCOL_RANGE, .CMD_MODE, .RF_ON,
  .REPORT_VALID, .REPORT);

/* File: dv/host_model.sv */
// Host terminal model sending command lines
`timescale 1ns/1ns
module host_model
(
  input wire logic clk,
  output logic valid,
  output logic [7:0] chr
);
  initial
  begin
    valid = 1'b0;
    chr = 8'hA5;
  end
  // Hash, body, carriage return, back to back
  task automatic send(input string s);
    string t;
    t = {"#", s, "\015"};
    for (int i = 0; i < t.len(); i++)
    begin
      @(posedge clk);
      valid <= 1'b1;
      chr <= t[i];
    end
    @(posedge clk);
    valid <= 1'b0;
    chr <= ~t[t.len()-1];
  endtask
endmodule // host_model

/* File: dv/reader_sensitivity_and_error_reporter_test.sv */
// Self-checking bench for the sensitivity and error reporter
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin fail_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module reader_sensitivity_and_error_reporter_test
  import sens_err_pkg::*;
;
  logic clk, rst_n, rx_valid, pll_lock, rf_req, cmd_mode, rf_on, rep_valid;
  logic [7:0] rx_char, sb;
  logic [4:0] ev, truck, alt, e_truck, e_alt, v;
  logic [31:0] r;
  logic [31:0] seed = 32'h2D03AE9A;
  report_t rep, last;
  serial_cfg_t ser;
  int nrep, fail_count, checked, cyc;
  string bad[6] = '{"64320", "6431G", "6431", "643123", "999", "64312345678"};
  host_model host (.clk(clk), .valid(rx_valid), .chr(rx_char));
  sens_err_reporter uut (.CLK(clk), .RST_N(rst_n), .RX_VALID(rx_valid), .RX_CHAR(rx_char), .DIAG_FAIL(ev[0]),
    .PARAM_LOST(ev[1]), .PLL_LOCK(pll_lock), .RF_ACK_TIMEOUT(ev[2]), .RF_INIT_TIMEOUT(ev[3]),
    .RF_STATUS_BAD(ev[4]), .RF_STATUS_BYTE(sb), .RF_ENABLE_REQ(rf_req), .TRUCK_TAG_PROTOCOL_RANGE(truck),
    .ALT_PROTOCOL_RANGE(alt), .CMD_MODE(cmd_mode), .RF_ON(rf_on), .REPORT_VALID(rep_valid), .REPORT(rep),
    .SERIAL_CFG(ser));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (rep_valid)
    begin
      last = rep;
      nrep++;
    end
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Waits for exactly one new report
  task automatic expect_rep(input msg_code_t c);
    int n0;
    n0 = nrep;
    for (int i = 0; i < 20 && nrep == n0; i++)
      @(posedge clk);
    #1;
    `CHK("report count", n0 + 1, nrep)
    `CHK("report code", c, last.code)
  endtask
  task automatic quiet();
    int n0;
    n0 = nrep;
    repeat (6) @(posedge clk);
    `CHK("no report", n0, nrep)
  endtask
  task automatic check_rng();
    `CHK("truck range", e_truck, truck)
    `CHK("alt range", e_alt, alt)
  endtask
  task automatic fire(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 5'h00;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    ev = 5'h00;
    pll_lock = 1'b1;
    sb = 8'h00;
    rf_req = 1'b1;
    e_truck = 5'h1F;
    e_alt = 5'h1F;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_rng();
    `CHK("serial cfg", {17'h02580, 4'h8, 2'h1, 1'b0}, ser)
    `CHK("rf follows", 1'b1, rf_on)
    host.send("64310");
    expect_rep(MSG_ERR_GENERIC);
    check_rng();
    host.send("01");
    expect_rep(MSG_DONE);
    `CHK("command mode", 1'b1, cmd_mode)
    for (int i = 0; i < 12; i++)
    begin
      r = xs();
      v = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : r[4:0];
      host.send($sformatf("64%0d%02h", r[8] ? 5 : 3, v));
      if (r[8])
        e_alt = v;
      else
        e_truck = v;
      quiet();
      check_rng();
    end
    host.send("6451F");
    e_alt = 5'h1F;
    quiet();
    check_rng();
    foreach (bad[i])
    begin
      host.send(bad[i]);
      expect_rep(MSG_ERR_GENERIC);
      check_rng();
    end
    fire(0);
    expect_rep(MSG_ERR_GENERIC);
    fire(1);
    expect_rep(MSG_ERR06);
    `CHK("rf off lost", 1'b0, rf_on)
    host.send("647915");
    repeat (4) @(posedge clk);
    `CHK("rf back", 1'b1, rf_on)
    @(posedge clk);
    pll_lock <= 1'b0;
    rf_req <= 1'b0;
    expect_rep(MSG_ERR07);
    `CHK("rf off unlock", 1'b0, rf_on)
    @(posedge clk);
    pll_lock <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("rf restored", 1'b1, rf_on)
    expect_rep(MSG_ERR08);
    `CHK("rf follows req", 1'b0, rf_on)
    fire(2);
    expect_rep(MSG_ERR_RF1);
    fire(3);
    expect_rep(MSG_ERR_RF2);
    r = xs();
    @(posedge clk);
    sb <= r[7:0];
    fire(4);
    expect_rep(MSG_ERR_RF3);
    `CHK("status byte", r[7:0], last.status)
    host.send("00");
    quiet();
    `CHK("data mode", 1'b0, cmd_mode)
    host.send("64501");
    expect_rep(MSG_ERR_GENERIC);
    check_rng();
    stop_test();
  end
endmodule // reader_sensitivity_and_error_reporter_test
